/* File: design/uart_interrupt_identification.sv */
`timescale 1ns/100ps
`default_nettype none
module uart_interrupt_identification
   import iid_pkg::*;
#(
   parameter int CNT_W = 5
) (
   // clock and reset
   input wire logic CLOCK,
   input wire logic RESET,
   // apb slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [31:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // receive path events
   input wire logic RX_ERROR,
   input wire logic LINE_STATUS_READ,
   input wire logic [CNT_W-1:0] RX_LEVEL,
   input wire logic RX_FIFO_ACTIVITY,
   input wire logic BAUD_TICK,
   // transmit path events
   input wire logic [CNT_W-1:0] TX_LEVEL,
   input wire logic THR_WRITE,
   // modem inputs and status read
   input wire modem_t MODEM_IN,
   input wire logic MODEM_STATUS_READ,
   // auto-baud events
   input wire logic AB_DONE,
   input wire logic AB_TIMEOUT,
   // configuration seen by the rest of the port
   output ctrl_t CTRL
);

   // ****************************************************************
   // declarations
   // ****************************************************************
   typedef enum logic [2:0] {
      TX_IDLE = 3'h1,   // waiting for the fifo to empty
      TX_DELAY = 3'h2,  // start-up delay running
      TX_DONE = 3'h4    // empty event handled
   } tx_state_t;

   tx_state_t tx_state_ff;        // transmit empty sequencer
   tx_state_t nxt_tx_state;       // its next value
   logic [11:0] delay_ff;         // start-up delay counter
   logic [11:0] delay_len;        // one character minus stop bit
   logic two_seen_ff;             // fifo held two at once
   logic rls_ff;                  // line error pending
   logic transmit_empty_source_ff;                 // transmit empty pending
   logic modem_ff;                // modem status pending
   logic ab_done_ff;              // auto-baud done latched
   logic ab_to_ff;                // auto-baud timeout latched
   modem_t modem_prev_ff;         // modem inputs one cycle back
   logic modem_event;             // any qualifying modem change
   logic receive_data_available_source;                     // receive level at trigger
   logic character_timeout_source;                     // character timeout expired
   logic [CNT_W-1:0] trig_level;  // selected trigger
   logic [3:0] word_bits;         // data bits per character
   logic transmit_empty_source_set;                // transmit empty raised now
   logic [2:0] code;              // highest pending code
   logic pend_n;                  // active-low pending
   logic [31:0] ident;            // live identification word
   logic [2:0] snap_code_ff;      // code shown by current read
   logic snap_pend_n_ff;          // pending flag shown by read
   logic setup;                   // apb setup cycle
   logic done;                    // apb transfer completes
   logic ident_read;              // identification read completes
   logic ctrl_write;              // control register write
   logic abclr_write;             // auto-baud clear write

   // ****************************************************************
   // apb phases
   // ****************************************************************
   assign setup = PSEL && !PENABLE;
   assign done = PSEL && PENABLE && PREADY;
   assign ident_read = done && !PWRITE && PADDR == ADDR_IDENT;
   assign ctrl_write = done && PWRITE && PADDR == ADDR_CTRL;
   assign abclr_write = done && PWRITE && PADDR == ADDR_ABCLR;

   // ready one cycle into the access phase
   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         PREADY <= 1'b0;
      end else begin
         PREADY <= PSEL && PENABLE && !PREADY;
      end
   end

   // read data and error captured at setup, frozen for the access
   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         PRDATA <= RST_DATA;
         PSLVERR <= 1'b0;
         snap_code_ff <= CODE_MODEM;
         snap_pend_n_ff <= 1'b1;
      end else if (setup) begin
         PSLVERR <= 1'b0;
         PRDATA <= RST_DATA;
         case (PADDR)
            ADDR_IDENT: begin
               if (PWRITE) begin
                  PSLVERR <= 1'b1; // read-only word
               end else begin
                  PRDATA <= ident;
                  snap_code_ff <= code;
                  snap_pend_n_ff <= pend_n;
               end
            end
            ADDR_CTRL: begin
               PRDATA <= 32'(CTRL);
            end
            ADDR_ABCLR: begin
               PSLVERR <= !PWRITE; // write-only word
            end
            default: begin
               PSLVERR <= 1'b1; // unmapped
            end
         endcase
      end
   end

   // control register
   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         CTRL <= ctrl_t'(RST_CTRL);
      end else if (ctrl_write) begin
         CTRL <= ctrl_t'(PWDATA[CTRL_W-1:0]);
      end
   end

   // ****************************************************************
   // receive sources
   // ****************************************************************
   // trigger level select
   always_comb begin
      case (CTRL.rx_trig)
         2'h0: trig_level = CNT_W'(TRIG_L0);
         2'h1: trig_level = CNT_W'(TRIG_L1);
         2'h2: trig_level = CNT_W'(TRIG_L2);
         2'h3: trig_level = CNT_W'(TRIG_L3);
         default: trig_level = CNT_W'(TRIG_L0);
      endcase
   end

   assign word_bits = 4'(WORD_BASE + 4'(CTRL.word_len));
   assign receive_data_available_source = RX_LEVEL >= trig_level;

   // idle timer for the receive fifo
   char_timeout #(
      .CNT_W(CNT_W)
   ) u_cti (
      .clock(CLOCK),
      .reset(RESET),
      .tick(BAUD_TICK),
      .activity(RX_FIFO_ACTIVITY),
      .level(RX_LEVEL),
      .trig(trig_level),
      .word_bits(word_bits),
      .expired(character_timeout_source)
   );

   // line error flag, set wins over the clearing read
   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         rls_ff <= 1'b0;
      end else if (RX_ERROR) begin
         rls_ff <= 1'b1;
      end else if (LINE_STATUS_READ) begin
         rls_ff <= 1'b0;
      end
   end

   // ****************************************************************
   // transmit empty source
   // ****************************************************************
   assign delay_len = 12'((12'h001 + 12'(word_bits) + 12'(CTRL.parity_en)) * TICKS_PER_BIT);

   // remembers a fill of two or more since the last empty event
   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         two_seen_ff <= 1'b0;
      end else if (TX_LEVEL >= CNT_W'(TWO_CHARS)) begin
         two_seen_ff <= 1'b1;
      end else if (tx_state_ff == TX_DONE) begin
         two_seen_ff <= 1'b0;
      end
   end

   // empty sequencer next state
   always_comb begin
      nxt_tx_state = tx_state_ff;
      transmit_empty_source_set = 1'b0;
      case (tx_state_ff)
         TX_IDLE: begin
            if (TX_LEVEL == '0) begin
               if (two_seen_ff) begin
                  transmit_empty_source_set = 1'b1;
                  nxt_tx_state = TX_DONE;
               end else begin
                  nxt_tx_state = TX_DELAY;
               end
            end
         end
         TX_DELAY: begin
            if (TX_LEVEL != '0) begin
               nxt_tx_state = TX_IDLE; // refilled during the delay
            end else if (BAUD_TICK && 12'(delay_ff + 12'h001) >= delay_len) begin
               transmit_empty_source_set = 1'b1;
               nxt_tx_state = TX_DONE;
            end
         end
         TX_DONE: begin
            if (TX_LEVEL != '0) begin
               nxt_tx_state = TX_IDLE;
            end
         end
         default: begin
            nxt_tx_state = TX_IDLE;
         end
      endcase
   end

   // empty sequencer state
   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         tx_state_ff <= TX_IDLE;
      end else begin
         tx_state_ff <= nxt_tx_state;
      end
   end

   // start-up delay counter
   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         delay_ff <= 12'h000;
      end else if (tx_state_ff != TX_DELAY) begin
         delay_ff <= 12'h000;
      end else if (BAUD_TICK) begin
         delay_ff <= 12'(delay_ff + 12'h001);
      end
   end

   // transmit empty flag, set wins
   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         transmit_empty_source_ff <= 1'b0;
      end else if (transmit_empty_source_set) begin
         transmit_empty_source_ff <= 1'b1;
      end else if (THR_WRITE) begin
         transmit_empty_source_ff <= 1'b0;
      end else if (ident_read && !snap_pend_n_ff && snap_code_ff == CODE_TRANSMIT_EMPTY_SOURCE) begin
         transmit_empty_source_ff <= 1'b0;
      end
   end

   // ****************************************************************
   // modem source
   // ****************************************************************
   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         modem_prev_ff <= modem_t'(4'h0);
      end else begin
         modem_prev_ff <= MODEM_IN;
      end
   end

   assign modem_event = (MODEM_IN.dcd != modem_prev_ff.dcd)
                     || (MODEM_IN.dsr != modem_prev_ff.dsr)
                     || (MODEM_IN.cts != modem_prev_ff.cts)
                     || (MODEM_IN.ri && !modem_prev_ff.ri);

   // modem flag, set wins
   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         modem_ff <= 1'b0;
      end else if (modem_event) begin
         modem_ff <= 1'b1;
      end else if (MODEM_STATUS_READ) begin
         modem_ff <= 1'b0;
      end
   end

   // ****************************************************************
   // auto-baud events
   // ****************************************************************
   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         ab_done_ff <= 1'b0;
         ab_to_ff <= 1'b0;
      end else begin
         if (AB_DONE) begin
            ab_done_ff <= 1'b1;
         end else if (abclr_write && PWDATA[ID_ABDONE_BIT]) begin
            ab_done_ff <= 1'b0;
         end
         if (AB_TIMEOUT) begin
            ab_to_ff <= 1'b1;
         end else if (abclr_write && PWDATA[ID_ABTO_BIT]) begin
            ab_to_ff <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // priority encoder and identification word
   // ****************************************************************
   always_comb begin
      pend_n = 1'b0;
      if (rls_ff && CTRL.rls_en) begin
         code = CODE_RLS;
      end else if (receive_data_available_source && CTRL.rda_en) begin
         code = CODE_RDA;
      end else if (character_timeout_source && CTRL.rda_en) begin
         code = CODE_CTI;
      end else if (transmit_empty_source_ff && CTRL.transmit_empty_source_en) begin
         code = CODE_TRANSMIT_EMPTY_SOURCE;
      end else if (modem_ff && CTRL.modem_en) begin
         code = CODE_MODEM;
      end else begin
         code = CODE_MODEM;
         pend_n = 1'b1;
      end
   end

   // only listed codes reach the field
   always_comb begin
      ident = RST_DATA;
      ident[ID_PEND_BIT] = pend_n;
      ident[ID_CODE_LSB +: 3] = code;
      ident[ID_FIFO_LO] = CTRL.fifo_en;
      ident[ID_FIFO_HI] = CTRL.fifo_en;
      ident[ID_ABDONE_BIT] = ab_done_ff && CTRL.ab_done_en;
      ident[ID_ABTO_BIT] = ab_to_ff && CTRL.ab_to_en;
   end

endmodule // uart_interrupt_identification
`default_nettype wire

/* File: design/iid_pkg.sv */
// ****************************************************************
// constants and carriers for the identification block
// ****************************************************************
package iid_pkg;

   // ****************************************************************
   // register map, byte addresses
   // ****************************************************************
   localparam logic [31:0] ADDR_IDENT = 32'he0010008;  // identification, read only
   localparam logic [31:0] ADDR_CTRL = 32'he0010100;   // enables and line setup
   localparam logic [31:0] ADDR_ABCLR = 32'he0010104;  // auto-baud clear, write only

   // ****************************************************************
   // identification field codes
   // ****************************************************************
   localparam logic [2:0] CODE_RLS = 3'h3;   // receive line error
   localparam logic [2:0] CODE_RDA = 3'h2;   // receive data available
   localparam logic [2:0] CODE_CTI = 3'h6;   // character timeout
   localparam logic [2:0] CODE_TRANSMIT_EMPTY_SOURCE = 3'h1;  // transmit holding empty
   localparam logic [2:0] CODE_MODEM = 3'h0; // modem status / none

   // ****************************************************************
   // identification register bit positions
   // ****************************************************************
   localparam int ID_PEND_BIT = 0;   // active-low pending flag
   localparam int ID_CODE_LSB = 1;   // code field 3:1
   localparam int ID_FIFO_LO = 6;    // fifo enable copy
   localparam int ID_FIFO_HI = 7;    // fifo enable copy
   localparam int ID_ABDONE_BIT = 8; // auto-baud done
   localparam int ID_ABTO_BIT = 9;   // auto-baud timeout

   // ****************************************************************
   // reset values
   // ****************************************************************
   localparam logic [31:0] RST_DATA = 32'h00000000;

   // ****************************************************************
   // receive trigger levels, in characters
   // ****************************************************************
   localparam logic [4:0] TRIG_L0 = 5'h01;
   localparam logic [4:0] TRIG_L1 = 5'h04;
   localparam logic [4:0] TRIG_L2 = 5'h08;
   localparam logic [4:0] TRIG_L3 = 5'h0e;

   // ****************************************************************
   // timing figures, in baud clock ticks
   // ****************************************************************
   localparam logic [11:0] CTI_MUL = 12'h007;   // word length factor
   localparam logic [11:0] CTI_SUB = 12'h002;   // subtracted bits
   localparam logic [11:0] CTI_SCALE = 12'h008; // ticks per unit
   localparam logic [11:0] CTI_ADD = 12'h001;   // final offset
   localparam logic [11:0] TICKS_PER_BIT = 12'h010; // oversampling ratio
   localparam logic [3:0] WORD_BASE = 4'h5;     // bits for length code 00
   localparam logic [4:0] TWO_CHARS = 5'h02;    // fill level arming no delay

   // ****************************************************************
   // carriers
   // ****************************************************************
   typedef struct packed {
      logic dcd;  // carrier detect
      logic ri;   // ring indicator
      logic dsr;  // data set ready
      logic cts;  // clear to send
   } modem_t;

   typedef struct packed {
      logic [1:0] word_len;   // 00=5 .. 11=8 bits
      logic parity_en;        // parity bit present
      logic [1:0] rx_trig;    // receive trigger select
      logic fifo_en;          // fifo enable
      logic ab_to_en;         // auto-baud timeout enable
      logic ab_done_en;       // auto-baud done enable
      logic modem_en;         // modem source enable
      logic rls_en;           // line error source enable
      logic transmit_empty_source_en;          // transmit empty enable
      logic rda_en;           // receive data / timeout enable
   } ctrl_t;

   localparam int CTRL_W = $bits(ctrl_t);
   localparam logic [CTRL_W-1:0] RST_CTRL = 12'h000;

endpackage

/* File: design/char_timeout.sv */
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// character timeout timer, counts baud ticks of receive idleness
// ****************************************************************
module char_timeout
   import iid_pkg::*;
#(
   parameter int CNT_W = 5
) (
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // receive side
   input wire logic tick,
   input wire logic activity,
   input wire logic [CNT_W-1:0] level,
   input wire logic [CNT_W-1:0] trig,
   input wire logic [3:0] word_bits,
   // result
   output logic expired
);

   logic [11:0] count_ff;  // ticks since last activity
   logic [11:0] limit;     // interval for the present fill
   logic [11:0] gap;       // trigger minus characters, clamped

   // interval from word length and fill level
   always_comb begin
      gap = (trig > level) ? 12'(trig - level) : 12'h000;
      limit = 12'((12'(word_bits) * CTI_MUL - CTI_SUB) * CTI_SCALE)
            + 12'(gap * CTI_SCALE + CTI_ADD);
   end

   // idle counter, restarted by any fifo activity
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         count_ff <= 12'h000;
         expired <= 1'b0;
      end else if (activity || level == '0) begin
         count_ff <= 12'h000;
         expired <= 1'b0;
      end else if (tick && !expired) begin
         count_ff <= 12'(count_ff + 12'h001);
         if (12'(count_ff + 12'h001) >= limit) begin
            expired <= 1'b1;
         end
      end
   end

endmodule // char_timeout
`default_nettype wire

/* File: test/uart_interrupt_identification_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// port checks for the identification block
// ****************************************************************
module uart_interrupt_identification_asserts
   import iid_pkg::*;
(
   // clock and reset
   input wire logic CLOCK,
   input wire logic RESET,
   // apb
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [31:0] PADDR,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   // events and setup
   input wire logic RX_ERROR,
   input wire logic LINE_STATUS_READ,
   input wire ctrl_t CTRL
);
   default clocking @(posedge CLOCK); endclocking
   default disable iff (RESET);
   // setup edge of an identification read
   wire logic id_setup = PSEL && !PENABLE && !PWRITE && (PADDR == ADDR_IDENT);
   // completing edge of an identification read
   wire logic id_done = PREADY && PSEL && !PWRITE && (PADDR == ADDR_IDENT);
   // unmapped place
   wire logic bad_addr = !(PADDR inside {ADDR_IDENT, ADDR_CTRL, ADDR_ABCLR});

   a_one_wait_state: assert property (PSEL && !PENABLE |=> !PREADY ##1 PREADY)
      else $error("ready not on second access cycle");
   a_ready_pulse: assert property (PREADY |=> !PREADY)
      else $error("ready longer than one cycle");
   a_no_reserved: assert property (id_done |-> !(PRDATA[3:1] inside {3'h4, 3'h5, 3'h7}))
      else $error("reserved source code read");
   a_fifo_copy: assert property (id_done |-> PRDATA[7:6] == {2{CTRL.fifo_en}})
      else $error("fifo enable copy wrong");
   a_done_gated: assert property (id_done && PRDATA[8] |-> CTRL.ab_done_en)
      else $error("baud done shown while disabled");
   a_tout_gated: assert property (id_done && PRDATA[9] |-> CTRL.ab_to_en)
      else $error("baud timeout shown while disabled");
   a_idle_code: assert property (id_done && PRDATA[0] |-> PRDATA[3:1] == 3'h0)
      else $error("code not zero when idle");
   a_line_err_first: assert property ((RX_ERROR && CTRL.rls_en && !LINE_STATUS_READ)
      ##1 !LINE_STATUS_READ ##1 (id_setup && CTRL.rls_en) |=> PRDATA[3:0] == 4'h6)
      else $error("line error not reported first");
   a_bad_addr_err: assert property (PSEL && !PENABLE && bad_addr |=> PSLVERR && PRDATA == 32'h0)
      else $error("unmapped access not refused");

   c_line_err: cover property (id_done && PRDATA[3:0] == 4'h6);
   c_tx_empty: cover property (id_done && PRDATA[3:0] == 4'h2);
   c_char_tout: cover property (id_done && PRDATA[3:0] == 4'hc);
endmodule // uart_interrupt_identification_asserts

bind uart_interrupt_identification uart_interrupt_identification_asserts
   uart_interrupt_identification_asserts_i (.CLOCK(CLOCK), .RESET(RESET), .PSEL(PSEL),
   .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
   .PSLVERR(PSLVERR), .RX_ERROR(RX_ERROR), .LINE_STATUS_READ(LINE_STATUS_READ), .CTRL(CTRL));
`default_nettype wire

/* File: test/tb_uart_interrupt_identification.sv */
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// self-checking bench for the identification block
// ****************************************************************
module tb_uart_interrupt_identification import iid_pkg::*;;
   logic clock, reset, psel, penable, pwrite, pready, pslverr, tick, erf;
   logic [31:0] paddr, pwdata, prdata, rd;
   logic [4:0] rx_level, tx_level;
   logic [6:0] ev; // error, lsr read, activity, thr write, msr read, done, timeout
   modem_t modem;
   ctrl_t ctrl;
   int err_count, check_count, cycles;
   typedef struct packed {
      logic [11:0] c;
      logic [4:0] l;
      logic [3:0] m;
      logic [6:0] e;
      logic [11:0] x;
   } row_t;
   // setup, fill, modem lines, events, expected identification
   row_t rows [0:18] = '{
      '{12'h040, 5'h00, 4'h0, 7'h00, 12'h0c1},
      '{12'h001, 5'h01, 4'h0, 7'h00, 12'h004},
      '{12'h081, 5'h03, 4'h0, 7'h00, 12'h001},
      '{12'h081, 5'h04, 4'h0, 7'h00, 12'h004},
      '{12'h101, 5'h08, 4'h0, 7'h00, 12'h004},
      '{12'h181, 5'h0d, 4'h0, 7'h00, 12'h001},
      '{12'h185, 5'h0e, 4'h0, 7'h40, 12'h006},
      '{12'h185, 5'h0e, 4'h0, 7'h20, 12'h004},
      '{12'h008, 5'h00, 4'h1, 7'h00, 12'h000},
      '{12'h008, 5'h00, 4'h1, 7'h04, 12'h001},
      '{12'h008, 5'h00, 4'h5, 7'h00, 12'h000},
      '{12'h008, 5'h00, 4'h5, 7'h04, 12'h001},
      '{12'h008, 5'h00, 4'h1, 7'h00, 12'h001},
      '{12'h000, 5'h00, 4'h1, 7'h40, 12'h001},
      '{12'h004, 5'h00, 4'h1, 7'h00, 12'h006},
      '{12'h004, 5'h00, 4'h1, 7'h20, 12'h001},
      '{12'h010, 5'h00, 4'h1, 7'h02, 12'h101},
      '{12'h000, 5'h00, 4'h1, 7'h00, 12'h001},
      '{12'h030, 5'h00, 4'h1, 7'h01, 12'h301}};

   uart_interrupt_identification #(.CNT_W(5)) uart_interrupt_identification_i (
      .CLOCK(clock), .RESET(reset), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .RX_ERROR(ev[6]), .LINE_STATUS_READ(ev[5]), .RX_LEVEL(rx_level),
      .RX_FIFO_ACTIVITY(ev[4]), .BAUD_TICK(tick), .TX_LEVEL(tx_level), .THR_WRITE(ev[3]),
      .MODEM_IN(modem), .MODEM_STATUS_READ(ev[2]), .AB_DONE(ev[1]), .AB_TIMEOUT(ev[0]),
      .CTRL(ctrl));

   // 25 MHz clock
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end

   // hang guard
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         err_count++;
         end_sim();
      end
   end

   // one apb transfer, held until ready is seen
   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      // ready and read data taken at the same rising edge
      do begin
         @(posedge clock);
      end while (pready !== 1'b1);
      rd = prdata;
      erf = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // one-cycle event pulses
   task automatic fire(input logic [6:0] m);
      @(posedge clock);
      ev <= m;
      @(posedge clock);
      ev <= 7'h00;
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge clock);
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic end_sim();
      $display("checks=%0d errors=%0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // main sequence
   initial begin
      {reset, tick} = 2'h3;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {rx_level, tx_level, ev, modem} = '0;
      {err_count, check_count, cycles} = '0;
      repeat (10) @(posedge clock);
      chk({prdata[31:1], pready}, 32'h0);
      chk({20'h0, ctrl}, 32'h0);
      reset <= 1'b0;
      apb(1'b0, ADDR_IDENT, 32'h0);
      chk(rd, 32'h1);
      foreach (rows[i]) begin
         rx_level <= rows[i].l;
         modem <= rows[i].m;
         apb(1'b1, ADDR_CTRL, {20'h0, rows[i].c});
         fire(rows[i].e | 7'h10);
         apb(1'b0, ADDR_IDENT, 32'h0);
         chk(rd, {20'h0, rows[i].x});
      end
      // refused places
      apb(1'b0, 32'he0010200, 32'h0);
      chk({erf, rd[30:0]}, 32'h80000000);
      apb(1'b1, ADDR_IDENT, 32'hffffffff);
      chk({31'h0, erf}, 32'h1);
      apb(1'b0, ADDR_ABCLR, 32'h0);
      chk({erf, rd[30:0]}, 32'h80000000);
      // control word reads back and drives the port
      apb(1'b0, ADDR_CTRL, 32'h0);
      chk(rd, 32'h030);
      chk({20'h0, ctrl}, 32'h030);
      // baud flags cleared only by the clear register
      apb(1'b1, ADDR_ABCLR, 32'h100);
      apb(1'b0, ADDR_IDENT, 32'h0);
      chk(rd, 32'h201);
      apb(1'b1, ADDR_ABCLR, 32'h200);
      apb(1'b0, ADDR_IDENT, 32'h0);
      chk(rd, 32'h1);
      // line error raised in the access phase waits for the next read
      apb(1'b1, ADDR_CTRL, 32'h004);
      fork
         apb(1'b0, ADDR_IDENT, 32'h0);
         begin
            @(posedge clock);
            fire(7'h40);
         end
      join
      chk(rd, 32'h1);
      apb(1'b0, ADDR_IDENT, 32'h0);
      chk(rd, 32'h6);
      fire(7'h20);
      // transmit empty above pending modem change
      modem <= 4'h0;
      apb(1'b1, ADDR_CTRL, 32'h00a);
      apb(1'b0, ADDR_IDENT, 32'h0);
      chk(rd, 32'h2);
      apb(1'b0, ADDR_IDENT, 32'h0);
      chk(rd, 32'h0);
      fire(7'h04);
      // single character: delayed by 96 ticks
      tx_level <= 5'h01;
      fire(7'h08);
      tx_level <= 5'h00;
      apb(1'b0, ADDR_IDENT, 32'h0);
      chk(rd, 32'h1);
      wt(80);
      apb(1'b0, ADDR_IDENT, 32'h0);
      chk(rd, 32'h1);
      wt(10);
      apb(1'b0, ADDR_IDENT, 32'h0);
      chk(rd, 32'h2);
      // two characters held: no delay
      tx_level <= 5'h02;
      fire(7'h08);
      tx_level <= 5'h00;
      wt(3);
      apb(1'b0, ADDR_IDENT, 32'h0);
      chk(rd, 32'h2);
      // timeout: 264 + 25 ticks with trigger 4, one held, ticks paused 40 cycles
      apb(1'b1, ADDR_CTRL, 32'h081);
      rx_level <= 5'h01;
      fire(7'h10);
      tick <= 1'b0;
      wt(40);
      tick <= 1'b1;
      wt(265);
      apb(1'b0, ADDR_IDENT, 32'h0);
      chk(rd, 32'h1);
      wt(30);
      apb(1'b0, ADDR_IDENT, 32'h0);
      chk(rd, 32'hc);
      fire(7'h10);
      apb(1'b0, ADDR_IDENT, 32'h0);
      chk(rd, 32'h1);
      // reset in mid-run clears flags, control and bus outputs
      fire(7'h40);
      wt(1);
      reset <= 1'b1;
      wt(2);
      chk({pslverr, pready, 18'h0, ctrl}, 32'h0);
      chk(prdata, 32'h0);
      reset <= 1'b0;
      apb(1'b1, ADDR_CTRL, 32'h00e);
      apb(1'b0, ADDR_IDENT, 32'h0);
      chk(rd, 32'h1);
      end_sim();
   end
endmodule // tb_uart_interrupt_identification
`default_nettype wire
